//--- inc/hpc_pkg.sv
// Purpose: shared constants and types for the host port pin control block
// Assumes: one clock domain (mclk, 20 MHz), active-low asynchronous reset
// Notes: the block has no software-visible registers
package hpc_pkg;

  // ****************************************************************
  // widths and encodings
  // ****************************************************************
  localparam int HPC_ADDR_W = 16;
  localparam int HPC_DATA_W = 8;
  localparam logic [1:0] HPC_SEL_CTRL = 2'h0;   // control register
  localparam logic [1:0] HPC_SEL_DATA_INC = 2'h1;  // data, pointer post-increment
  localparam logic [1:0] HPC_SEL_ADDR = 2'h2;   // address pointer register
  localparam logic [1:0] HPC_SEL_DATA = 2'h3;   // data, pointer fixed

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] HPC_ADDR_RST = 16'h0000;
  localparam logic HPC_INT_N_RST = 1'h1;
  localparam logic HPC_STRAP_RST = 1'h0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int HPC_CLK_MHZ = 20;
  localparam int HPC_BUSY_NS = 100;  // least time ready stays low after a strobe
  localparam int HPC_BUSY_CYC = (HPC_BUSY_NS * HPC_CLK_MHZ + 999) / 1000;

  typedef enum logic [3:0] {
    HPC_IDLE = 4'h1,
    HPC_ACTIVE = 4'h2,
    HPC_BUSY = 4'h4,
    HPC_DONE = 4'h8
  } hpc_state_t;

endpackage

//--- inc/hpc_sync_if.sv
// Purpose: carries synchronised host pin levels between sync stage and core
// Assumes: single clock domain
// Notes: levels only, already filtered
`timescale 1ns/1ps
`default_nettype none
interface hpc_sync_if;
  logic addr_strobe_n;
  logic data_strobe_n;
  logic port_select_n;
  logic read_not_write;
  logic reg_select_lo;
  logic reg_select_hi;
  logic port_select_strap;
  logic wide_port_mode;
  modport src (output addr_strobe_n, data_strobe_n, port_select_n, read_not_write,
    reg_select_lo, reg_select_hi, port_select_strap, wide_port_mode);
  modport dst (input addr_strobe_n, data_strobe_n, port_select_n, read_not_write,
    reg_select_lo, reg_select_hi, port_select_strap, wide_port_mode);
endinterface
`default_nettype wire

//--- logic/hpc_pin_sync.sv
// Purpose: three-stage synchronisers for the host port strobe, select and strap pins (addr_byte is not synchronised)
// Assumes: pins are asynchronous to mclk; reset is held for at least four clocks
// Notes: a level is taken only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module hpc_pin_sync
  import hpc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic [WIDTH-1:0] pins,
  hpc_sync_if.src sync
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] lvl_r;

  // ****************************************************************
  // synchroniser chain
  // ****************************************************************
  // stage one feeds stage two only; no reset on purpose: the chain keeps
  // tracking the straps while the chip is held in reset, so the strap
  // capture on release sees the pin and not a reset value
  always_ff @(posedge mclk) begin
    s1_r <= pins;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // filtered level per bit, moves only when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_flt
      always_ff @(posedge mclk) begin
        if (s2_r[g] == s3_r[g]) begin
          lvl_r[g] <= s3_r[g];
        end
      end
    end
  endgenerate

  // every pin, straps included, goes to the core through the same filter
  assign sync.addr_strobe_n = lvl_r[0];
  assign sync.data_strobe_n = lvl_r[1];
  assign sync.port_select_n = lvl_r[2];
  assign sync.read_not_write = lvl_r[3];
  assign sync.reg_select_lo = lvl_r[4];
  assign sync.reg_select_hi = lvl_r[5];
  assign sync.port_select_strap = lvl_r[6];
  assign sync.wide_port_mode = lvl_r[7];

endmodule
`default_nettype wire

//--- logic/hpc_host_port_ctrl.sv
// Purpose: pin-level control of the 8-bit multiplexed host port
// Assumes: host pins asynchronous to mclk; outputs-off control from pin
// Notes: no software registers; access results reported on core-side ports
`timescale 1ns/1ps
`default_nettype none

module hpc_host_port_ctrl
  import hpc_pkg::*;
#(
  parameter int BUSY_CYC = HPC_BUSY_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic addr_strobe_n,
  input wire logic data_strobe_n,
  input wire logic port_select_n,
  input wire logic read_not_write,
  input wire logic reg_select_lo,
  input wire logic reg_select_hi,
  input wire logic port_select_strap,
  input wire logic wide_port_mode,
  input wire logic outputs_off_n,
  input wire logic [HPC_DATA_W-1:0] addr_byte,
  input wire logic core_int_req,
  input wire logic core_int_clr,
  output logic host_ready_o,
  output logic host_ready_oe,
  output logic host_interrupt_n_o,
  output logic host_interrupt_n_oe,
  output logic port_enabled,
  output logic pullup_en,
  output logic holder_en,
  output logic [HPC_ADDR_W-1:0] address_pointer_reg,
  output logic xfer_pulse,
  output logic xfer_read,
  output logic [1:0] xfer_sel
);

  // ****************************************************************
  // registers and internal nets
  // ****************************************************************
  hpc_sync_if sif ();
  hpc_state_t st_r;
  logic strap_r;
  logic wide_r;
  logic strap_taken_r;
  logic ads_d_r;
  logic ds_d_r;
  logic addr_hi_r;
  logic int_n_r;
  logic [7:0] busy_cnt_r;
  logic [HPC_ADDR_W-1:0] ptr_r;
  logic xfer_pulse_r;
  logic xfer_read_r;
  logic [1:0] xfer_sel_r;
  logic ads_fall;
  logic ds_fall;
  logic selected;

  // ****************************************************************
  // register select decode
  // ****************************************************************
  // decode of the register selects, used for pointer and transfer paths
  function automatic logic [1:0] sel_decode(input logic wide, input logic lo, input logic hi);
    sel_decode = wide ? HPC_SEL_DATA_INC : {hi, lo};
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  hpc_pin_sync #(.WIDTH(8)) u_sync (
    .mclk(mclk),
    .pins({wide_port_mode, port_select_strap, reg_select_hi, reg_select_lo,
      read_not_write, port_select_n, data_strobe_n, addr_strobe_n}),
    .sync(sif.src)
  );

  // ****************************************************************
  // strap capture
  // ****************************************************************
  // straps taken on the first clock after reset release, then frozen
  // limitation: reset must last four clocks so a new strap level has passed the filter
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strap_taken_r <= 1'h0;
      strap_r <= HPC_STRAP_RST;
      wide_r <= 1'h0;
    end else if (!strap_taken_r) begin
      strap_taken_r <= 1'h1;
      strap_r <= sif.port_select_strap;
      wide_r <= sif.wide_port_mode;
    end
  end

  assign port_enabled = strap_r;
  assign pullup_en = !strap_r;
  assign holder_en = !strap_r;
  assign selected = strap_r && !sif.port_select_n;

  // ****************************************************************
  // strobe edges
  // ****************************************************************
  // delayed levels reset to the idle-high pin level, so no false edge follows reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ads_d_r <= 1'h1;
      ds_d_r <= 1'h1;
    end else begin
      ads_d_r <= sif.addr_strobe_n;
      ds_d_r <= sif.data_strobe_n;
    end
  end

  assign ads_fall = ads_d_r && !sif.addr_strobe_n;
  assign ds_fall = ds_d_r && !sif.data_strobe_n;

  // ****************************************************************
  // address pointer
  // ****************************************************************
  // two address strobes fill the pointer, high byte first
  // data with post-increment bumps the pointer the cycle after the transfer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ptr_r <= HPC_ADDR_RST;
      addr_hi_r <= 1'h1;
    end else if (selected && ads_fall) begin
      addr_hi_r <= !addr_hi_r;
      if (addr_hi_r) begin
        ptr_r[15:8] <= addr_byte;
      end else begin
        ptr_r[7:0] <= addr_byte;
      end
    end else if (xfer_pulse_r && xfer_sel_r == HPC_SEL_DATA_INC) begin
      ptr_r <= ptr_r + 16'h0001;
    end
  end

  assign address_pointer_reg = ptr_r;

  // ****************************************************************
  // transfer sequencer
  // ****************************************************************
  // ready drops after each selected data strobe until the hold-off ends and the strobe lifts; hazard: a strobe
  // arriving while busy is not queued, the host must wait on ready
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r <= HPC_IDLE;
      busy_cnt_r <= 8'h00;
      xfer_pulse_r <= 1'h0;
      xfer_read_r <= 1'h0;
      xfer_sel_r <= 2'h0;
    end else begin
      xfer_pulse_r <= 1'h0;
      case (st_r)
        // idle: a qualified data strobe starts one transfer
        HPC_IDLE: begin
          if (selected && ds_fall) begin
            st_r <= HPC_BUSY;
            busy_cnt_r <= 8'(BUSY_CYC);
            xfer_pulse_r <= 1'h1;
            xfer_read_r <= sif.read_not_write;
            xfer_sel_r <= sel_decode(wide_r, sif.reg_select_lo, sif.reg_select_hi);
          end
        end
        // busy: fixed hold-off before the port may answer again
        HPC_BUSY: begin
          if (busy_cnt_r <= 8'h01) begin
            st_r <= HPC_DONE;
          end else begin
            busy_cnt_r <= busy_cnt_r - 8'h01;
          end
        end
        // done: wait for the host to lift the strobe, so one strobe is one transfer
        HPC_DONE: begin
          if (sif.data_strobe_n) begin
            st_r <= HPC_IDLE;
          end
        end
        default: st_r <= HPC_IDLE;
      endcase
    end
  end

  assign xfer_pulse = xfer_pulse_r;
  assign xfer_read = xfer_read_r;
  assign xfer_sel = xfer_sel_r;

  // ****************************************************************
  // ready and interrupt pins
  // ****************************************************************
  // ready is decoded from the state register, so it drops with the transfer pulse
  assign host_ready_o = strap_r && (st_r == HPC_IDLE);
  // enables follow outputs_off_n with no register, so the pins float at once
  assign host_ready_oe = outputs_off_n && strap_r;

  // ****************************************************************
  // interrupt flag
  // ****************************************************************
  // core raises the request only with the port strapped on and not in wide mode; core-side clear by core_int_clr, set wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      int_n_r <= HPC_INT_N_RST;
    end else if (core_int_req && strap_r && !wide_r) begin
      int_n_r <= 1'h0;
    end else if (core_int_clr) begin
      int_n_r <= 1'h1;
    end
  end

  assign host_interrupt_n_o = int_n_r;
  assign host_interrupt_n_oe = outputs_off_n && (!resetn || !wide_r);

endmodule
`default_nettype wire

//--- dv/hpc_host_port_ctrl_properties.sv
// Purpose: concurrent checks on the host port pin control ports
// Assumes: one mclk domain, resetn async active low
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module hpc_ctrl_props (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic outputs_off_n,
  input wire logic wide_port_mode,
  input wire logic host_ready_o,
  input wire logic host_ready_oe,
  input wire logic host_interrupt_n_o,
  input wire logic host_interrupt_n_oe,
  input wire logic port_enabled,
  input wire logic pullup_en,
  input wire logic holder_en,
  input wire logic xfer_pulse,
  input wire logic xfer_read,
  input wire logic [1:0] xfer_sel
);
  // ****
  // checks
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  chk_ready_off_z: assert property (!outputs_off_n |-> !host_ready_oe)
    else $error("ready driven while outputs off");
  chk_int_off_z: assert property (!outputs_off_n |-> !host_interrupt_n_oe)
    else $error("interrupt driven while outputs off");
  chk_int_reset_high: assert property ($rose(resetn) |-> host_interrupt_n_o)
    else $error("interrupt low leaving reset");
  // two edges of slack: the strap lands on the first edge after release
  chk_strap_held: assert property ($past(resetn, 2) |-> $stable(port_enabled))
    else $error("port select changed outside reset");
  chk_pullup_off: assert property (pullup_en == !port_enabled && (port_enabled || holder_en))
    else $error("pullup or holder wrong for strap");
  chk_no_xfer_off: assert property (!port_enabled |-> !xfer_pulse)
    else $error("transfer while port deselected");
  chk_ready_busy: assert property (xfer_pulse |=> !host_ready_o [*2])
    else $error("ready back too soon");
  chk_pulse_single: assert property (xfer_pulse |=> !xfer_pulse)
    else $error("transfer pulse too long");
  chk_wide_sel: assert property (wide_port_mode && xfer_pulse |-> xfer_sel == 2'h1)
    else $error("select used in wide mode");
  cov_read: cover property (xfer_pulse && xfer_read);
  cov_write: cover property (xfer_pulse && !xfer_read);
  cov_off: cover property (!outputs_off_n);
endmodule
`default_nettype wire

//--- dv/hpc_host_model.sv
// Purpose: external host driving the multiplexed port pins
// Assumes: ready seen as z when not driven
// Notes: strobe held well past the busy window, then ready awaited
`timescale 1ns/1ps
`default_nettype none
module hpc_host_model (
  input wire logic mclk,
  input wire logic ready,
  output logic addr_strobe_n,
  output logic data_strobe_n,
  output logic port_select_n,
  output logic read_not_write,
  output logic reg_select_lo,
  output logic reg_select_hi,
  output logic [7:0] addr_byte
);
  // strobes, select and read_not_write idle high, register selects low, byte lines arbitrary
  initial begin
    {addr_strobe_n, data_strobe_n, port_select_n, read_not_write} = 4'hF;
    {reg_select_hi, reg_select_lo} = 2'h0;
    addr_byte = 8'h00;
  end
  // one access; ok reports ready seen within a bounded wait
  task automatic access(input logic adr, input logic rd, input logic [1:0] sel,
    input logic [7:0] b, input logic csn, output logic ok);
    int n = 0;
    @(posedge mclk);
    port_select_n <= csn;
    read_not_write <= rd;
    {reg_select_hi, reg_select_lo} <= sel;
    addr_byte <= b;
    @(posedge mclk);
    if (adr) addr_strobe_n <= 1'b0;
    else data_strobe_n <= 1'b0;
    repeat (12) @(posedge mclk);
    addr_strobe_n <= 1'b1;
    data_strobe_n <= 1'b1;
    while (ready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    ok = (ready === 1'b1);
    port_select_n <= 1'b1;
    addr_byte <= ~b;
  endtask
endmodule
`default_nettype wire

//--- dv/hpc_host_port_ctrl_tb_top.sv
// Purpose: self-checking bench for host port pin control
// Assumes: BUSY_CYC left at its default
// Notes: address strobe pulses are not scored, pointer is checked instead
`timescale 1ns/1ps
`default_nettype none
module hpc_host_port_ctrl_tb_top;
  import hpc_pkg::*;
  logic mclk = 0, resetn = 0, port_select_strap = 1, wide_port_mode = 0;
  logic outputs_off_n = 1, core_int_req = 0, core_int_clr = 0, ok;
  logic addr_strobe_n, data_strobe_n, port_select_n, read_not_write, reg_select_lo, reg_select_hi;
  logic [7:0] addr_byte;
  logic host_ready_o, host_ready_oe, host_interrupt_n_o, host_interrupt_n_oe;
  logic port_enabled, pullup_en, holder_en, xfer_pulse, xfer_read;
  logic [1:0] xfer_sel, s;
  logic [15:0] address_pointer_reg, ptr;
  logic [2:0] exp_q[$];
  int errors = 0, checked = 0, seed = 73, cyc = 0;
  wire host_ready = host_ready_oe ? host_ready_o : 1'bz;
  always #25 mclk = ~mclk;
  hpc_host_model hpc_host_model_inst (.mclk, .ready(host_ready), .addr_strobe_n, .data_strobe_n,
    .port_select_n, .read_not_write, .reg_select_lo, .reg_select_hi, .addr_byte);
  hpc_host_port_ctrl hpc_host_port_ctrl_inst (.mclk, .resetn, .addr_strobe_n, .data_strobe_n,
    .port_select_n, .read_not_write, .reg_select_lo, .reg_select_hi, .port_select_strap,
    .wide_port_mode, .outputs_off_n, .addr_byte, .core_int_req, .core_int_clr, .host_ready_o,
    .host_ready_oe, .host_interrupt_n_o, .host_interrupt_n_oe, .port_enabled, .pullup_en,
    .holder_en, .address_pointer_reg, .xfer_pulse, .xfer_read, .xfer_sel);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // reset with straps set well before release
  task automatic rst(input logic strap, input logic wide);
    resetn <= 1'b0;
    port_select_strap <= strap;
    wide_port_mode <= wide;
    repeat (5) @(posedge mclk);
    chk(16'(host_interrupt_n_o), 16'h1);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(16'(port_enabled), 16'(strap));
  endtask
  // scoreboard side: every data transfer must match the oldest note
  always @(posedge mclk) begin
    if (resetn && xfer_pulse === 1'b1) begin
      if (exp_q.size() == 0) chk(16'h1, 16'h0);
      else chk(16'({xfer_read, xfer_sel}), 16'(exp_q.pop_front()));
    end
  end
  // hang guard, the run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    rst(1'b1, 1'b0);
    ptr = 16'($random(seed));
    hpc_host_model_inst.access(1'b1, 1'b0, HPC_SEL_ADDR, ptr[15:8], 1'b0, ok);
    hpc_host_model_inst.access(1'b1, 1'b0, HPC_SEL_ADDR, ptr[7:0], 1'b0, ok);
    chk(address_pointer_reg, ptr);
    // two transfers to each of control, data inc, address and data fixed
    for (int i = 0; i < 8; i++) begin
      s = 2'(i >> 1);
      exp_q.push_back({i[0], s});
      hpc_host_model_inst.access(1'b0, i[0], s, 8'($random(seed)), 1'b0, ok);
      if (s == HPC_SEL_DATA_INC) ptr++;
      chk(16'(ok), 16'h1);
      chk(address_pointer_reg, ptr);
    end
    hpc_host_model_inst.access(1'b0, 1'b1, HPC_SEL_DATA, 8'h00, 1'b1, ok);
    $display("test transfers done");
    outputs_off_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(16'({host_ready_oe, host_interrupt_n_oe}), 16'h0);
    outputs_off_n <= 1'b1;
    core_int_req <= 1'b1;
    @(posedge mclk);
    core_int_req <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(16'(host_interrupt_n_o), 16'h0);
    core_int_clr <= 1'b1;
    @(posedge mclk);
    core_int_clr <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(16'(host_interrupt_n_o), 16'h1);
    $display("test outputs and interrupt done");
    rst(1'b0, 1'b0);
    chk(16'({port_enabled, pullup_en, holder_en}), 16'h3);
    hpc_host_model_inst.access(1'b0, 1'b1, HPC_SEL_DATA, 8'h5A, 1'b0, ok);
    port_select_strap <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(16'(port_enabled), 16'h0);
    $display("test strap done");
    rst(1'b1, 1'b1);
    exp_q.push_back({1'b0, HPC_SEL_DATA_INC});
    hpc_host_model_inst.access(1'b0, 1'b0, HPC_SEL_CTRL, 8'hA5, 1'b0, ok);
    core_int_req <= 1'b1;
    @(posedge mclk);
    core_int_req <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(16'(host_interrupt_n_oe & ~host_interrupt_n_o), 16'h0);
    chk(16'(exp_q.size()), 16'h0);
    $display("test wide mode done");
    wrap_up();
  end
endmodule
bind hpc_host_port_ctrl hpc_ctrl_props hpc_ctrl_props_inst (.mclk, .resetn, .outputs_off_n,
  .wide_port_mode, .host_ready_o, .host_ready_oe, .host_interrupt_n_o, .host_interrupt_n_oe,
  .port_enabled, .pullup_en, .holder_en, .xfer_pulse, .xfer_read, .xfer_sel);
`default_nettype wire
